// File: include/loop_readout_cfg.svh
`ifndef LOOP_READOUT_CFG_SVH
`define LOOP_READOUT_CFG_SVH

// register byte offsets
`define OFS_STATUS 8'h00
`define OFS_CTRL 8'h04
`define OFS_APPLY 8'h08
`define OFS_CFG_BASE 2'b01
`define OFS_RES_BASE 3'b100

// control register fields
`define CTRL_COUNT_LSB 0
`define CTRL_RANGE_LSB 8
`define CTRL_SCALE_LSB 12
`define CTRL_CLAMP_LSB 16
`define CTRL_RESET 32'h0000_0F04

// status fields
`define ST_SELFTEST_BIT 0
`define ST_SUPPLY_BIT 1
`define ST_DNV_BIT 2

// converter and scan
`define CHAN_NUM 4
`define RAW_MAX 14'h3FFF
`define FLOOR_CODE 14'h0CCD
`define BREAK_CODE 14'h0C00
`define SCAN_PERIOD_MS 45
`define CLK_HZ 50000000
// divide first: the plain product would overflow 32-bit integer math
`define SLOT_CYC (`CLK_HZ / 1000 * `SCAN_PERIOD_MS / `CHAN_NUM)

`endif

// File: include/loop_readout_pkg.sv
package loop_readout_pkg;

  typedef enum logic [2:0] {
    SC_WAIT_SLOT, SC_START, SC_CONVERT, SC_STORE_RAW, SC_STORE_ENG
  } scan_state_t;

  typedef struct packed {
    logic [13:0] raw_min;
    logic [13:0] raw_max;
    logic [15:0] eng_min;
    logic [15:0] eng_max;
  } ch_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic we;
    logic [2:0] waddr;
    logic [15:0] wdata;
  } mem_wr_t;

endpackage

// File: rtl/loop_readout.sv
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "loop_readout_cfg.svh"
module loop_readout
  import loop_readout_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `SLOT_CYC
)
(
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic conv_done, // converter result ready pin
  input wire logic [13:0] conv_code, // converter code pin
  input wire logic selftest_pass, // self-test passed pin
  input wire logic field_supply_ok, // field supply present pin
  output logic conv_start, // start conversion pulse
  output logic [1:0] conv_chan // channel to convert
);
  logic [31:0] ctrl_r;
  ch_cfg_t cfg_r [`CHAN_NUM];
  bus_req_t req_r;
  logic rd_wait_r;
  logic cfg_dirty_r;
  logic configured_r;
  logic selftest_fail_r;
  logic [3:0] brk_r;
  logic [1:0] done_s_r, pass_s_r, sup_s_r;
  logic done_d_r;
  logic [13:0] code_s1_r, code_s2_r;
  scan_state_t st_r;
  logic [31:0] slot_cnt_r;
  logic [1:0] ch_r;
  logic [13:0] raw_r;
  logic [15:0] eng_nxt;
  logic [2:0] rd_addr;
  logic [15:0] mem_rdata;
  mem_wr_t mem_wr;
  logic [2:0] ch_count;
  logic [23:0] status_word;
  logic [7:0] module_health_flags;
  logic [7:0] loop_break_flags;
  logic [7:0] spare_status_byte;
  logic dnv;
  logic done_rise;
  logic wr_en;

  // bus slave
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_r <= '0;
    end else if (hready) begin
      req_r.valid <= hsel & htrans[1];
      req_r.write <= hwrite;
      req_r.addr <= haddr[7:0];
    end
  end

  // reads take one wait state so the result store can answer from a flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      rd_wait_r <= 1'b0;
    end else if (hready & hsel & htrans[1] & ~hwrite) begin
      hreadyout <= 1'b0;
      rd_wait_r <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
      rd_wait_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign wr_en = req_r.valid & req_r.write;
  assign rd_addr = {haddr[4], haddr[3:2]};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      hrdata <= 32'h0000_0000;
      if (req_r.addr == `OFS_STATUS) begin
        hrdata <= {8'h00, status_word};
      end else if (req_r.addr == `OFS_CTRL) begin
        hrdata <= ctrl_r;
      end else if (req_r.addr[7:6] == `OFS_CFG_BASE) begin
        unique case (req_r.addr[3:2])
          2'd0: hrdata <= {18'h0, cfg_r[req_r.addr[5:4]].raw_min};
          2'd1: hrdata <= {18'h0, cfg_r[req_r.addr[5:4]].raw_max};
          2'd2: hrdata <= {16'h0, cfg_r[req_r.addr[5:4]].eng_min};
          2'd3: hrdata <= {16'h0, cfg_r[req_r.addr[5:4]].eng_max};
        endcase
      end else if (req_r.addr[7:5] == `OFS_RES_BASE) begin
        hrdata <= {16'h0, mem_rdata};
      end
    end
  end

  // configuration
  // only the low 3 bits of the count field are kept; 16-bit data not offered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_en && req_r.addr == `OFS_CTRL) begin
      ctrl_r <= {12'h000, hwdata[19:8], 5'h00, hwdata[2:0]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `CHAN_NUM; g++) begin : g_cfg
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cfg_r[g].raw_min <= 14'h0000;
          cfg_r[g].raw_max <= `RAW_MAX;
          cfg_r[g].eng_min <= 16'h0000;
          cfg_r[g].eng_max <= 16'h3FFF;
        end else if (wr_en && req_r.addr[7:6] == `OFS_CFG_BASE &&
                     req_r.addr[5:4] == 2'(g)) begin
          unique case (req_r.addr[3:2])
            2'd0: cfg_r[g].raw_min <= hwdata[13:0];
            2'd1: cfg_r[g].raw_max <= hwdata[13:0];
            2'd2: cfg_r[g].eng_min <= hwdata[15:0];
            2'd3: cfg_r[g].eng_max <= hwdata[15:0];
          endcase
        end
      end
    end
  endgenerate

  // any new parameter makes the data suspect until it is applied
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      configured_r <= 1'b0;
      cfg_dirty_r <= 1'b0;
    end else if (wr_en && req_r.addr == `OFS_APPLY) begin
      configured_r <= 1'b1;
      cfg_dirty_r <= 1'b0;
    end else if (wr_en && (req_r.addr == `OFS_CTRL ||
                           req_r.addr[7:6] == `OFS_CFG_BASE)) begin
      cfg_dirty_r <= 1'b1;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // reset high so a done pin left high gives no false edge
      done_s_r <= 2'b11;
      pass_s_r <= 2'b11;
      sup_s_r <= 2'b11;
      done_d_r <= 1'b1;
    end else begin
      done_s_r <= {done_s_r[0], conv_done};
      pass_s_r <= {pass_s_r[0], selftest_pass};
      sup_s_r <= {sup_s_r[0], field_supply_ok};
      done_d_r <= done_s_r[1];
    end
  end

  // code passes the same two flops as done, so it is sampled on the edge that first sees done high
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      code_s1_r <= 14'h0000;
      code_s2_r <= 14'h0000;
    end else begin
      code_s1_r <= conv_code;
      code_s2_r <= code_s1_r;
    end
  end

  assign done_rise = done_s_r[1] & ~done_d_r;

  // status
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      selftest_fail_r <= 1'b0;
    end else if (~pass_s_r[1]) begin
      selftest_fail_r <= 1'b1;
    end
  end

  assign dnv = ~configured_r | cfg_dirty_r;
  always_comb begin
    module_health_flags = 8'h00;
    module_health_flags[`ST_SELFTEST_BIT] = selftest_fail_r;
    module_health_flags[`ST_SUPPLY_BIT] = ~sup_s_r[1];
    module_health_flags[`ST_DNV_BIT] = dnv;
    loop_break_flags = {4'h0, brk_r};
    spare_status_byte = 8'h00;
    status_word = {spare_status_byte, loop_break_flags,
                   module_health_flags};
  end

  // scan sequencer
  assign ch_count = (ctrl_r[2:0] == 3'd0 || ctrl_r[2:0] > 3'd4) ?
                    3'd4 : ctrl_r[2:0];

  // fewer channels wrap sooner, so the whole scan gets shorter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= SC_START;
      slot_cnt_r <= 32'd0;
      ch_r <= 2'd0;
      conv_start <= 1'b0;
      conv_chan <= 2'd0;
      raw_r <= 14'h0000;
    end else begin
      conv_start <= 1'b0;
      if (slot_cnt_r != 32'd0) begin
        slot_cnt_r <= slot_cnt_r - 32'd1;
      end
      unique case (st_r)
        SC_START: begin
          conv_start <= 1'b1;
          conv_chan <= ch_r;
          // start and the wait exit take one cycle each of the slot
          slot_cnt_r <= SLOT_CYC - 32'd2;
          st_r <= SC_CONVERT;
        end
        SC_CONVERT: begin
          if (done_rise) begin
            if (ctrl_r[`CTRL_RANGE_LSB + ch_r]) begin
              // (code - 4 mA floor) * 5/4 spans 16 mA over full scale
              if (code_s2_r <= `FLOOR_CODE) begin
                raw_r <= 14'h0000;
              end else if (({2'b00, code_s2_r} - {2'b00, `FLOOR_CODE})
                           * 16'd5 / 16'd4 > {2'b00, `RAW_MAX}) begin
                raw_r <= `RAW_MAX;
              end else begin
                raw_r <= 14'(({2'b00, code_s2_r} - {2'b00, `FLOOR_CODE})
                             * 16'd5 / 16'd4);
              end
            end else begin
              raw_r <= code_s2_r;
            end
            st_r <= SC_STORE_RAW;
          end
        end
        SC_STORE_RAW: st_r <= SC_STORE_ENG;
        SC_STORE_ENG: st_r <= SC_WAIT_SLOT;
        SC_WAIT_SLOT: begin
          if (slot_cnt_r == 32'd0) begin
            ch_r <= ({1'b0, ch_r} + 3'd1 >= ch_count) ? 2'd0 :
                    ch_r + 2'd1;
            st_r <= SC_START;
          end
        end
      endcase
    end
  end

  // loop-break judged on the unscaled converter code
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      brk_r <= 4'h0;
    end else if (st_r == SC_CONVERT && done_rise) begin
      brk_r[ch_r] <= ctrl_r[`CTRL_RANGE_LSB + ch_r] &
                     (code_s2_r < `BREAK_CODE);
    end
  end

  // scaling
  // combinational divide: slow path, but only one result per slot
  logic signed [17:0] d_raw, s_raw, s_eng;
  logic signed [35:0] prod, quot, sum;
  logic signed [16:0] lo, hi;
  always_comb begin
    d_raw = 18'(signed'({4'h0, raw_r})) -
            18'(signed'({4'h0, cfg_r[ch_r].raw_min}));
    s_raw = 18'(signed'({4'h0, cfg_r[ch_r].raw_max})) -
            18'(signed'({4'h0, cfg_r[ch_r].raw_min}));
    s_eng = 18'(signed'(cfg_r[ch_r].eng_max)) -
            18'(signed'(cfg_r[ch_r].eng_min));
    prod = 36'(d_raw) * 36'(s_eng);
    quot = (s_raw == 18'sd0) ? 36'sd0 : prod / 36'(s_raw);
    sum = 36'(signed'(cfg_r[ch_r].eng_min)) + quot;
    lo = 17'(signed'(cfg_r[ch_r].eng_min));
    hi = 17'(signed'(cfg_r[ch_r].eng_max));
    if (lo > hi) begin
      lo = 17'(signed'(cfg_r[ch_r].eng_max));
      hi = 17'(signed'(cfg_r[ch_r].eng_min));
    end
    if (ctrl_r[`CTRL_CLAMP_LSB + ch_r] && sum < 36'(lo)) begin
      eng_nxt = 16'(lo);
    end else if (ctrl_r[`CTRL_CLAMP_LSB + ch_r] && sum > 36'(hi)) begin
      eng_nxt = 16'(hi);
    end else if (sum > 36'sd32767) begin
      eng_nxt = 16'h7FFF;
    end else if (sum < -36'sd32768) begin
      eng_nxt = 16'h8000;
    end else begin
      eng_nxt = 16'(sum);
    end
    if (~ctrl_r[`CTRL_SCALE_LSB + ch_r]) begin
      eng_nxt = {2'b00, raw_r};
    end
  end

  always_comb begin
    mem_wr.we = (st_r == SC_STORE_RAW) || (st_r == SC_STORE_ENG);
    mem_wr.waddr = {st_r == SC_STORE_ENG, ch_r};
    mem_wr.wdata = (st_r == SC_STORE_ENG) ? eng_nxt : {2'b00, raw_r};
  end

  result_store u_store (
    .clk_sys(clk_sys),
    .wr(mem_wr),
    .raddr(rd_addr),
    .rdata(mem_rdata)
  );
endmodule

// File: rtl/result_store.sv
`timescale 1ns/1ps
module result_store
  import loop_readout_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire mem_wr_t wr, // write port
  input wire logic [2:0] raddr, // read address
  output logic [15:0] rdata // registered read data
);
  logic [15:0] mem [8];

  always_ff @(posedge clk_sys) begin
    if (wr.we) begin
      mem[wr.waddr] <= wr.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    rdata <= mem[raddr];
  end
endmodule

// File: sim/conv_front_model.sv
`timescale 1ns/1ps
module conv_front_model (
  input wire logic clk_sys, // clock
  input wire logic conv_start, // slot start
  input wire logic [1:0] conv_chan, // channel
  input wire logic [3:0][13:0] codes, // loop codes
  input wire logic [7:0] lat, // answer delay
  output logic conv_done, // result ready
  output logic [13:0] conv_code // result code
);
  logic busy = 1'b0;
  logic pend = 1'b0;
  logic [7:0] cnt = '0;
  logic done_q = 1'b0;
  logic [13:0] code_q = '0;
  assign conv_done = done_q;
  assign conv_code = code_q;
  always @(posedge clk_sys) begin
    pend <= 1'b0;
    if (conv_start) begin
      busy <= 1'b1;
      cnt <= lat;
      done_q <= 1'b0;
      // code no longer held: show junk, not the old value
      code_q <= ~code_q;
    end else if (busy) begin
      if (cnt == 8'h00) begin
        code_q <= codes[conv_chan];
        busy <= 1'b0;
        pend <= 1'b1;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
    if (pend) done_q <= 1'b1;
  end
endmodule

// File: sim/loop_readout_props.sv
`timescale 1ns/1ps
module loop_readout_props #(
  parameter int unsigned SLOT_CYC = 200
)
(
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic conv_start, // slot start
  input wire logic [1:0] conv_chan // slot channel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire take = hsel & hready & htrans[1];
  logic [31:0] gap_r;
  logic seen_r;
  // first start after reset is unchecked: no earlier start to count from
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (conv_start) begin
      gap_r <= 32'h1;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 32'h1;
    end
  end
  sequence s_rd_take; take && !hwrite; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd_take |=> s_one_wait; endproperty
  property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
  property p_low_cause; $fell(hreadyout) |-> $past(take && !hwrite);
  endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_rdata_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata);
  endproperty
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  property p_chan_hold; !conv_start |-> $stable(conv_chan); endproperty
  property p_period; seen_r |-> (conv_start == (gap_r == SLOT_CYC));
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_low_cause: assert property (p_low_cause) else $error("stray wait");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  a_start_pulse: assert property (p_start_pulse) else $error("long start");
  a_chan_hold: assert property (p_chan_hold) else $error("chan moved");
  a_period: assert property (p_period) else $error("slot length");
endmodule
bind loop_readout loop_readout_props #(.SLOT_CYC(SLOT_CYC)) u_props (
  .clk_sys, .sys_rst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .conv_start, .conv_chan);

// File: sim/tb_top.sv
`timescale 1ns/1ps
`include "loop_readout_cfg.svh"
module tb_top;
  import loop_readout_pkg::*;
  localparam int unsigned SLOT = 200;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0, conv_chan;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, conv_start, conv_done;
  logic [13:0] conv_code;
  logic selftest_pass = 1'b1, field_supply_ok = 1'b1;
  logic [3:0][13:0] codes = {4{14'd8077}};
  logic [7:0] lat = 8'h03;
  int num_errors = 0, tests_run = 0;
  wire hready = hreadyout;
  initial forever #10 clk_sys = ~clk_sys;
  loop_readout #(.SLOT_CYC(SLOT)) dut (.clk_sys, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .conv_done, .conv_code, .selftest_pass, .field_supply_ok,
    .conv_start, .conv_chan);
  conv_front_model fe (.clk_sys, .conv_start, .conv_chan, .codes, .lat,
    .conv_done, .conv_code);
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  // sampled at the rising edge, before the slave's own update lands
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      print_verdict();
    end
    d = hrdata;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask
  task automatic slots(input int n);
    repeat (n * SLOT) @(posedge clk_sys);
  endtask
  task automatic t_reset_vals;
    rd_chk("ctrl", `OFS_CTRL, `CTRL_RESET);
    wr(`OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk("status", `OFS_STATUS, 32'h4);
    rd_chk("unmapped", 8'hFC, 32'h0);
  endtask
  task automatic t_apply;
    wr(`OFS_APPLY, 32'h1);
    rd_chk("dnv_clear", `OFS_STATUS, 32'h0);
    wr(`OFS_CTRL, `CTRL_RESET);
    rd_chk("dnv_set", `OFS_STATUS, 32'h4);
    wr(`OFS_APPLY, 32'h1);
  endtask
  task automatic t_ranges;
    logic [3:0][31:0] e;
    codes <= {14'd16381, 14'd3072, 14'd3071, 14'd8077};
    e = {32'd16380, 32'd0, 32'd0, 32'd6000};
    slots(5);
    rd_chk("break", `OFS_STATUS, 32'h200);
    for (int c = 0; c < 4; c++)
      rd_chk("raw420", 8'h80 + 8'(c * 4), e[c]);
    wr(`OFS_CTRL, 32'h4);
    wr(`OFS_APPLY, 32'h1);
    slots(5);
    rd_chk("nobreak", `OFS_STATUS, 32'h0);
    for (int c = 0; c < 4; c++)
      rd_chk("raw020", 8'h80 + 8'(c * 4), 32'(codes[c]));
  endtask
  task automatic t_scale;
    lat <= 8'd60;
    codes <= {14'd0, 14'd0, 14'd2000, 14'd500};
    wr(8'h44, 32'd1000);
    wr(8'h4C, 32'd100);
    wr(8'h54, 32'd1000);
    wr(8'h5C, 32'd100);
    wr(`OFS_CTRL, 32'h0002_3004);
    wr(`OFS_APPLY, 32'h1);
    slots(5);
    rd_chk("scaled", 8'h90, 32'd50);
    rd_chk("clamped", 8'h94, 32'd100);
    wr(`OFS_CTRL, 32'h0000_3004);
    wr(`OFS_APPLY, 32'h1);
    slots(5);
    rd_chk("unclamped", 8'h94, 32'd200);
  endtask
  task automatic t_chan_count;
    int bad;
    int one;
    bad = 0;
    one = 0;
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_APPLY, 32'h1);
    slots(2);
    repeat (4 * SLOT) begin
      @(negedge clk_sys);
      if (conv_start === 1'b1 && conv_chan[1] !== 1'b0) bad++;
      if (conv_start === 1'b1 && conv_chan === 2'd1) one++;
    end
    chk("chan_limit", 32'd0, 32'(bad));
    chk("chan1_used", 32'd2, 32'(one));
  endtask
  task automatic t_flags;
    field_supply_ok <= 1'b0;
    selftest_pass <= 1'b0;
    repeat (3) @(posedge clk_sys);
    selftest_pass <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd_chk("fault", `OFS_STATUS, 32'h3);
    field_supply_ok <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd_chk("sticky", `OFS_STATUS, 32'h1);
    codes <= {4{14'd8077}};
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk("after_rst", `OFS_STATUS, 32'h4);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_vals();
    t_apply();
    t_ranges();
    t_scale();
    t_chan_count();
    t_flags();
    print_verdict();
  end
endmodule
